/* rtl/tape_rw_error_control.sv */
/*
  Error collector for the tape synchronizer read-write section.
  Gathers error conditions, sets the shared read-write error flag and
  the numbered diagnostic flags, drives ending requests and character
  substitution. Assumes all inputs synchronous to ref_clk_i and that
  initialise_i pulses between operations.
*/
`timescale 1ns/1ns
module tape_rw_error_control #(
  parameter int RUNAWAY_TICKS = tape_rw_error_pkg::RUNAWAY_TENTHS_IN,
  parameter int SPROCKET_CYC  = tape_rw_error_pkg::SPROCKET_WIN_CYC
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          clk_en_i,
  input  wire logic                          initialise_i,
  input  wire tape_rw_error_pkg::op_state_t  op_i,
  input  wire tape_rw_error_pkg::ctl_check_t ctl_i,
  input  wire tape_rw_error_pkg::wr_check_t  wr_i,
  input  wire tape_rw_error_pkg::rd_check_t  rd_i,
  output logic                               rw_error_o,
  output logic [tape_rw_error_pkg::NUM_DIAG-1:0] diag_o,
  output logic                               continue_o,
  output logic                               continue_gap_o,
  output logic                               continue_check_o,
  output logic                               write_end_o,
  output logic                               read_end_o,
  output logic [5:0]                         out_char_o,
  output logic [4:0]                         in_char_o,
  output logic                               in_char_valid_o
);
  import tape_rw_error_pkg::*;

  // ==========================================================
  // Error detection (combinational)
  logic [NUM_DIAG-1:0] err;
  logic                rw_set;
  logic                in_err;
  logic                untrans;
  logic                read_errs_ok;
  logic                cont_bad;
  logic [11:0]         diff;
  logic                req_pending;
  logic                sprk_wait;
  logic                skew_pending;
  logic                write_end_armed;
  logic                end_next_group;
  logic [11:0]         sprk_cnt;
  logic [11:0]         run_cnt;

  // Read-side errors only count when the positioning checker is away
  assign read_errs_ok = !rd_i.checker_connected;
  assign diff = (rd_i.expected_count >= rd_i.actual_count) ?
                rd_i.expected_count - rd_i.actual_count :
                rd_i.actual_count - rd_i.expected_count;
  // Untranslatable only in numeric read-to-memory
  assign untrans = rd_i.in_char_valid && op_i.numeric_read_mem
                   && !rd_i.has_equivalent;
  assign in_err  = rd_i.in_char_valid && (!rd_i.in_parity_ok || untrans);
  assign cont_bad = op_i.continue_instr && (continue_check_o
                    || op_i.read_mem_ended || !op_i.op_active);

  always_comb begin
    err = '0;
    err[B_CONT] = cont_bad;
    err[B_WCNT] = !ctl_i.word_cnt_parity_ok;
    // Legal digit codes are 0..9 in this counter
    err[B_DCNT] = ctl_i.digit_code > 4'h9;
    err[B_OVFL] = ctl_i.mem_request && req_pending;
    err[B_MSEL] = ctl_i.addr_valid && (!ctl_i.addr_parity_ok
                  || ctl_i.addr > ADDR_LIMIT);
    err[B_MDAT] = ctl_i.data_valid && !ctl_i.data_parity_ok;
    err[B_CLUT] = op_i.write_op && op_i.ninth_word_done
                  && !wr_i.clutch_return;
    err[B_SPRK] = sprk_wait && sprk_cnt == 12'h000
                  && !wr_i.write_sprocket;
    err[B_OPAR] = wr_i.out_char_valid && !wr_i.out_parity_ok;
    if (read_errs_ok) begin
      err[B_OSKW] = rd_i.read_sprocket && skew_pending;
      err[B_BCNT] = rd_i.block_end && diff != 12'h000
                    && diff <= COUNT_DIFF_SMALL;
      err[B_VBCT] = rd_i.block_end && diff > COUNT_DIFF_SMALL;
      err[B_RUN]  = rd_i.tape_tick && !rd_i.data_seen
                    && run_cnt == 12'(RUNAWAY_TICKS - 1);
      err[B_IPAR] = rd_i.in_char_valid && !rd_i.in_parity_ok;
      err[B_UNTR] = untrans;
    end
  end

  // Shared flag: all but the non-hash input error set it directly;
  // outside the hash period that error needs its four qualifiers
  always_comb begin
    rw_set = |(err & ~((NUM_DIAG'(1) << B_IPAR)
                     | (NUM_DIAG'(1) << B_UNTR)));
    if (read_errs_ok && in_err) begin
      if (rd_i.hash_period) begin
        rw_set = 1'b1;
      end else if (rd_i.hash_period_gate && rd_i.read_check_qualifier
                   && rd_i.counter_term_inverted && rd_i.t04) begin
        rw_set = 1'b1;
      end
    end
  end

  // ==========================================================
  // Shared read-write error flag, sticky
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rw_error_o <= 1'b0;
    end else if (clk_en_i) begin
      if (rw_set) begin
        rw_error_o <= 1'b1;
      end else if (initialise_i) begin
        rw_error_o <= 1'b0;
      end
    end
  end

  // Diagnostic flags, one per numbered flip-flop; set beats clear
  genvar g;
  generate
    for (g = 0; g < NUM_DIAG; g++) begin : g_diag
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          diag_o[g] <= 1'b0;
        end else if (clk_en_i) begin
          if (err[g]) begin
            diag_o[g] <= 1'b1;
          end else if (initialise_i) begin
            diag_o[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Continue, continue-beyond-gap and continue-check flags
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      continue_o     <= 1'b0;
      continue_gap_o <= 1'b0;
    end else if (clk_en_i) begin
      if (rw_set || rw_error_o || initialise_i) begin
        continue_o     <= 1'b0;
        continue_gap_o <= 1'b0;
      end else begin
        if (op_i.continue_instr && !cont_bad) begin
          continue_o <= 1'b1;
        end else if (op_i.group_end) begin
          continue_o <= 1'b0;
        end
        if (op_i.continue_gap && !cont_bad) begin
          continue_gap_o <= 1'b1;
        end else if (op_i.group_end) begin
          continue_gap_o <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      continue_check_o <= 1'b0;
    end else if (clk_en_i) begin
      if (op_i.ninth_word_done && !continue_o) begin
        continue_check_o <= 1'b1;
      end else if (initialise_i) begin
        continue_check_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Write ending: error in words 1-9 ends this group, in the tenth
  // word the following group, because the tenth word's data is
  // already committed
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      write_end_armed <= 1'b0;
      end_next_group  <= 1'b0;
      write_end_o     <= 1'b0;
    end else if (clk_en_i) begin
      write_end_o <= 1'b0;
      if (initialise_i) begin
        write_end_armed <= 1'b0;
        end_next_group  <= 1'b0;
      end else if (op_i.write_op) begin
        if (op_i.group_end) begin
          if (write_end_armed) begin
            write_end_o     <= 1'b1;
            write_end_armed <= 1'b0;
          end
          if (end_next_group) begin
            write_end_armed <= 1'b1;
            end_next_group  <= 1'b0;
          end
        end
        if (err[B_CLUT]) begin
          write_end_armed <= 1'b1;
        end else if (rw_set && op_i.tenth_word) begin
          end_next_group <= 1'b1;
        end else if (rw_set) begin
          write_end_armed <= 1'b1;
        end
      end
    end
  end

  // Read ending on count mismatch or runaway
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      read_end_o <= 1'b0;
    end else if (clk_en_i) begin
      read_end_o <= err[B_BCNT] | err[B_VBCT] | err[B_RUN];
    end
  end

  // ==========================================================
  // Pending-state trackers for overflow and overskew
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      req_pending  <= 1'b0;
      skew_pending <= 1'b0;
    end else if (clk_en_i) begin
      if (ctl_i.mem_request) begin
        req_pending <= 1'b1;
      end else if (ctl_i.buffer_transfer || initialise_i) begin
        req_pending <= 1'b0;
      end
      if (rd_i.read_sprocket) begin
        skew_pending <= 1'b1;
      end else if (rd_i.skew_strobe || initialise_i) begin
        skew_pending <= 1'b0;
      end
    end
  end

  // Sprocket window: a sprocket must land within SPROCKET_CYC cycles
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sprk_wait <= 1'b0;
      sprk_cnt  <= 12'h000;
    end else if (clk_en_i) begin
      if (initialise_i || wr_i.write_sprocket
          || (sprk_wait && sprk_cnt == 12'h000)) begin
        sprk_wait <= 1'b0;
      end else if (wr_i.sprocket_expect) begin
        sprk_wait <= 1'b1;
        sprk_cnt  <= 12'(SPROCKET_CYC - 1);
      end else if (sprk_wait) begin
        sprk_cnt <= sprk_cnt - 12'h001;
      end
    end
  end

  // Runaway distance counter in tenths of an inch
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      run_cnt <= 12'h000;
    end else if (clk_en_i) begin
      if (initialise_i || rd_i.data_seen || err[B_RUN]) begin
        run_cnt <= 12'h000;
      end else if (rd_i.tape_tick) begin
        run_cnt <= run_cnt + 12'h001;
      end
    end
  end

  // ==========================================================
  // Character substitution paths, registered
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      out_char_o      <= 6'h00;
      in_char_o       <= 5'h00;
      in_char_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      out_char_o <= err[B_OPAR] ? ALL_ONES_CHAR : wr_i.out_char;
      in_char_valid_o <= rd_i.in_char_valid;
      if (untrans && !rd_i.hash_period) begin
        in_char_o <= PLUS_CODE;
      end else begin
        in_char_o <= rd_i.in_char;
      end
    end
  end

endmodule

/* rtl/tape_rw_error_pkg.sv */
/*
  Package for the tape read-write error collector: diagnostic numbers,
  timing constants, the plus code and the packed carriers for inputs.
  Assumes one 25 MHz clock and synchronous active-high reset.
*/
// How it works
// - Any control, write or read error sets its diagnostic, and shared error unless it is a non-hash input error
// - Diagnostic number: two digits name test instruction, last digit selects
// - Continue instruction at wrong time raises continue-check, diagnostic 47-5
// - Word counter parity failure raises word-counter error, diagnostic 47-3
// - Illegal digit counter code raises digit-counter error, diagnostic 47-9
// - Next memory request before transfer raises overflow, diagnostic 46-4
// - Address parity failure or address above 97499 sets diagnostic 46-2
// - Memory data parity failure raises memory-data error, diagnostic 46-1
// - Missing clutch return at ninth word sets 46-9, stop after tenth
// - Missing or late write sprocket raises sprocket-lost, diagnostic 47-4
// - Output character parity failure sets 46-6 and writes all ones
// - New read sprocket before previous strobe raises overskew, 47-8
// - Count difference of 1 to 12 sets 47-7 and starts read ending
// - Count difference above 12 sets 47-2 and starts read ending
// - Tape runaway 17.5 inches without data sets 46-0, starts read ending
// - Hash-period input parity failure sets 46-5 and shared error
// - Hash-period untranslatable character sets 46-3 and shared error
// - Other-period errors set 46-5 or 46-3; untranslatable becomes plus code
// - Untranslatable only in numeric read-to-memory with no one-digit equivalent
// - Non-hash input error sets shared error only with its four qualifiers
// - Setting shared error clears continue and continue-beyond-gap
// - Write error in words 1-9 ends at group end; tenth word, next group
package tape_rw_error_pkg;

  // ==========================================================
  // Diagnostic flip-flop numbers (instruction*10 + selector)
  localparam logic [9:0] DIAG_CONT_CHECK   = 10'd475;
  localparam logic [9:0] DIAG_WORD_CNT     = 10'd473;
  localparam logic [9:0] DIAG_DIGIT_CNT    = 10'd479;
  localparam logic [9:0] DIAG_OVERFLOW     = 10'd464;
  localparam logic [9:0] DIAG_MEM_SELECT   = 10'd462;
  localparam logic [9:0] DIAG_MEM_DATA     = 10'd461;
  localparam logic [9:0] DIAG_CLUTCH       = 10'd469;
  localparam logic [9:0] DIAG_SPROCKET     = 10'd474;
  localparam logic [9:0] DIAG_OUT_PARITY   = 10'd466;
  localparam logic [9:0] DIAG_OVERSKEW     = 10'd478;
  localparam logic [9:0] DIAG_BAD_COUNT    = 10'd477;
  localparam logic [9:0] DIAG_VBAD_COUNT   = 10'd472;
  localparam logic [9:0] DIAG_RUNAWAY      = 10'd460;
  localparam logic [9:0] DIAG_IN_PARITY    = 10'd465;
  localparam logic [9:0] DIAG_UNTRANS      = 10'd463;

  // ==========================================================
  // Other figures
  localparam int         NUM_DIAG          = 15;
  localparam logic [16:0] ADDR_LIMIT       = 17'h17cdb; // 97499
  localparam logic [11:0] COUNT_DIFF_SMALL = 12'h00c;   // 12
  localparam logic [4:0] PLUS_CODE         = 5'h07;     // 00111
  localparam logic [5:0] ALL_ONES_CHAR     = 6'h3f;
  localparam int         RUNAWAY_TENTHS_IN = 175;       // 17.5 inches
  localparam int         SPROCKET_WIN_NS   = 2000;
  localparam int         CLK_NS            = 40;
  localparam int         SPROCKET_WIN_CYC  =
    (SPROCKET_WIN_NS / CLK_NS) < 1 ? 1 : SPROCKET_WIN_NS / CLK_NS;

  // Diagnostic bit positions in the diag vector
  localparam int B_CONT = 0;
  localparam int B_WCNT = 1;
  localparam int B_DCNT = 2;
  localparam int B_OVFL = 3;
  localparam int B_MSEL = 4;
  localparam int B_MDAT = 5;
  localparam int B_CLUT = 6;
  localparam int B_SPRK = 7;
  localparam int B_OPAR = 8;
  localparam int B_OSKW = 9;
  localparam int B_BCNT = 10;
  localparam int B_VBCT = 11;
  localparam int B_RUN  = 12;
  localparam int B_IPAR = 13;
  localparam int B_UNTR = 14;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       continue_instr;   // 70 or 71 executed, one pulse
    logic       continue_gap;     // 71 executed, one pulse
    logic       ninth_word_done;  // ninth word of group written
    logic       tenth_word;       // tenth word being written
    logic       group_end;        // end of ten-word group
    logic       read_mem_ended;
    logic       op_active;        // read, check-read or write active
    logic       write_op;
    logic       numeric_read_mem;
  } op_state_t;

  typedef struct packed {
    logic       word_cnt_parity_ok;
    logic [3:0] digit_code;
    logic       mem_request;
    logic       buffer_transfer;
    logic       addr_valid;
    logic [16:0] addr;
    logic       addr_parity_ok;
    logic       data_valid;
    logic       data_parity_ok;
  } ctl_check_t;

  typedef struct packed {
    logic       clutch_return;
    logic       sprocket_expect;  // write sprocket due, pulse
    logic       write_sprocket;
    logic       out_char_valid;
    logic [5:0] out_char;
    logic       out_parity_ok;
  } wr_check_t;

  typedef struct packed {
    logic       checker_connected;
    logic       read_sprocket;
    logic       skew_strobe;
    logic       block_end;
    logic [11:0] expected_count;
    logic [11:0] actual_count;
    logic       tape_tick;        // one pulse per 0.1 inch of tape
    logic       data_seen;
    logic       in_char_valid;
    logic [4:0] in_char;
    logic       in_parity_ok;
    logic       has_equivalent;
    logic       hash_period;
    logic       hash_period_gate;
    logic       read_check_qualifier;
    logic       counter_term_inverted;
    logic       t04;
  } rd_check_t;

endpackage

/* verification/tape_rw_error_monitor.sv */
/*
  Checker for the tape read-write error collector: flag timing,
  shared error behaviour and character substitution.
  Assumes it is bound to tape_rw_error_control and sees only its ports.
*/
`timescale 1ns/1ns
module tape_rw_error_monitor
  import tape_rw_error_pkg::*;
(
  input wire logic                          ref_clk_i,
  input wire logic                          reset_i,
  input wire logic                          clk_en_i,
  input wire logic                          initialise_i,
  input wire tape_rw_error_pkg::op_state_t  op_i,
  input wire tape_rw_error_pkg::ctl_check_t ctl_i,
  input wire tape_rw_error_pkg::wr_check_t  wr_i,
  input wire tape_rw_error_pkg::rd_check_t  rd_i,
  input wire logic                          rw_error_o,
  input wire logic [14:0]                   diag_o,
  input wire logic                          continue_o,
  input wire logic                          continue_gap_o,
  input wire logic                          read_end_o,
  input wire logic [5:0]                    out_char_o,
  input wire logic [4:0]                    in_char_o
);
  // ==========================================================
  // Helpers
  logic [11:0] cnt_diff;

  // Count distance, either sign
  assign cnt_diff = (rd_i.expected_count > rd_i.actual_count) ?
    rd_i.expected_count - rd_i.actual_count :
    rd_i.actual_count - rd_i.expected_count;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // ==========================================================
  // Assertions
  a_mem_select:
  assert property (clk_en_i && ctl_i.addr_valid && (!ctl_i.addr_parity_ok
    || ctl_i.addr > ADDR_LIMIT) |=> diag_o[B_MSEL] && rw_error_o)
    else $error("memory select error not flagged");
  a_error_sticky:
  assert property (rw_error_o && !initialise_i |=> rw_error_o)
    else $error("shared error dropped without initialise");
  a_continue_clear:
  assert property ($rose(rw_error_o) |-> !continue_o && !continue_gap_o)
    else $error("continue flags survive shared error");
  a_continue_check:
  assert property (clk_en_i && op_i.continue_instr && !op_i.op_active
    |=> diag_o[B_CONT] && rw_error_o)
    else $error("continue check not flagged");
  a_word_parity:
  assert property (clk_en_i && !ctl_i.word_cnt_parity_ok
    |=> diag_o[B_WCNT])
    else $error("word counter error not flagged");
  a_digit_code:
  assert property (clk_en_i && ctl_i.digit_code > 4'h9 |=> diag_o[B_DCNT])
    else $error("digit counter error not flagged");
  a_out_subst:
  assert property (clk_en_i && wr_i.out_char_valid && !wr_i.out_parity_ok
    |=> out_char_o == ALL_ONES_CHAR && diag_o[B_OPAR])
    else $error("output parity substitution missing");
  a_plus_code:
  assert property (clk_en_i && rd_i.in_char_valid && !rd_i.hash_period
    && !rd_i.checker_connected && op_i.numeric_read_mem
    && !rd_i.has_equivalent |=> in_char_o == PLUS_CODE && diag_o[B_UNTR])
    else $error("plus code substitution missing");
  a_count_far:
  assert property (clk_en_i && rd_i.block_end && !rd_i.checker_connected
    && cnt_diff > COUNT_DIFF_SMALL |=> diag_o[B_VBCT] && read_end_o)
    else $error("very bad count not flagged");

  // Main scenarios reached
  c_error: cover property ($rose(rw_error_o));
  c_read_end: cover property (read_end_o);
  c_continue: cover property (continue_o && continue_gap_o);
endmodule

bind tape_rw_error_control tape_rw_error_monitor u_mon (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
  .initialise_i(initialise_i), .op_i(op_i), .ctl_i(ctl_i),
  .wr_i(wr_i), .rd_i(rd_i), .rw_error_o(rw_error_o), .diag_o(diag_o),
  .continue_o(continue_o), .continue_gap_o(continue_gap_o),
  .read_end_o(read_end_o), .out_char_o(out_char_o),
  .in_char_o(in_char_o)
);

/* verification/cpu_diag_model.sv */
/*
  Processor side of the diagnostic flags: a test instruction and
  selector digit return the state of the numbered flag.
  Assumes the flag vector follows the package bit positions.
*/
`timescale 1ns/1ns
module cpu_diag_model
  import tape_rw_error_pkg::*;
(
  input  wire logic [tape_rw_error_pkg::NUM_DIAG-1:0] diag_i,
  input  wire logic [6:0]                            instr_i,
  input  wire logic [3:0]                            sel_i,
  output logic                                       test_hit_o
);
  // Flag numbers in bit order, instruction times ten plus selector
  localparam logic [9:0] NUM [NUM_DIAG] = '{DIAG_CONT_CHECK,
    DIAG_WORD_CNT, DIAG_DIGIT_CNT, DIAG_OVERFLOW, DIAG_MEM_SELECT,
    DIAG_MEM_DATA, DIAG_CLUTCH, DIAG_SPROCKET, DIAG_OUT_PARITY,
    DIAG_OVERSKEW, DIAG_BAD_COUNT, DIAG_VBAD_COUNT, DIAG_RUNAWAY,
    DIAG_IN_PARITY, DIAG_UNTRANS};

  // Unknown numbers answer low, as an unset flag would
  always_comb begin
    test_hit_o = 1'b0;
    for (int b = 0; b < NUM_DIAG; b++) begin
      if (NUM[b] == 10'(instr_i) * 10'd10 + 10'(sel_i)) begin
        test_hit_o = diag_i[b];
      end
    end
  end
endmodule

/* verification/testbench.sv */
/*
  Self-checking bench for the tape read-write error collector.
  Assumes package, design, checker and model compile first.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samples_checked++; \
  if ((got) !== (ex)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module testbench;
  import tape_rw_error_pkg::*;
  logic        ref_clk_i, reset_i, clk_en_i, initialise_i;
  op_state_t   op_i, i_op, n_op;
  ctl_check_t  ctl_i, i_ctl, n_ctl;
  wr_check_t   wr_i, i_wr, n_wr;
  rd_check_t   rd_i, i_rd, n_rd;
  logic        rw_error_o, continue_o, continue_gap_o, continue_check_o;
  logic        write_end_o, read_end_o, in_char_valid_o, test_hit;
  logic [14:0] diag_o;
  logic [5:0]  out_char_o;
  logic [4:0]  in_char_o;
  logic [6:0]  instr;
  logic [3:0]  sel;
  int          bad_count, samples_checked;

  // Short counts keep the sprocket and runaway waits brief
  tape_rw_error_control #(.RUNAWAY_TICKS(4), .SPROCKET_CYC(4)) dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .initialise_i(initialise_i), .op_i(op_i), .ctl_i(ctl_i),
    .wr_i(wr_i), .rd_i(rd_i), .rw_error_o(rw_error_o), .diag_o(diag_o),
    .continue_o(continue_o), .continue_gap_o(continue_gap_o),
    .continue_check_o(continue_check_o), .write_end_o(write_end_o),
    .read_end_o(read_end_o), .out_char_o(out_char_o),
    .in_char_o(in_char_o), .in_char_valid_o(in_char_valid_o));
  cpu_diag_model cpu (.diag_i(diag_o), .instr_i(instr), .sel_i(sel),
    .test_hit_o(test_hit));

  // ==========================================================
  // Helpers
  function automatic logic [14:0] m(input int b);
    return 15'h0001 << b;
  endfunction

  // One cycle of stimulus then idle; outputs settled on return
  task automatic pulse_in;
    @(posedge ref_clk_i);
    op_i <= n_op;
    ctl_i <= n_ctl;
    wr_i <= n_wr;
    rd_i <= n_rd;
    @(posedge ref_clk_i);
    op_i <= i_op;
    ctl_i <= i_ctl;
    wr_i <= i_wr;
    rd_i <= i_rd;
    n_op = i_op;
    n_ctl = i_ctl;
    n_wr = i_wr;
    n_rd = i_rd;
    #1;
  endtask

  task automatic chk_diag(input logic [14:0] d, input logic e);
    `CHK("diag", d, diag_o)
    `CHK("rw_error", e, rw_error_o)
  endtask

  task automatic init;
    @(posedge ref_clk_i);
    initialise_i <= 1'b1;
    @(posedge ref_clk_i);
    initialise_i <= 1'b0;
    #1;
    chk_diag(15'h0000, 1'b0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_select;
    init();
    n_ctl.addr_valid = 1'b1;
    n_ctl.addr = 17'd97499;
    pulse_in();
    chk_diag(15'h0000, 1'b0);
    n_ctl.addr_valid = 1'b1;
    n_ctl.addr = 17'd97500;
    pulse_in();
    chk_diag(m(B_MSEL), 1'b1);
    instr = 7'd46;
    sel = 4'd2;
    #1 `CHK("test 46-2", 1'b1, test_hit)
    sel = 4'd1;
    #1 `CHK("test 46-1", 1'b0, test_hit)
    $display("t_select done");
  endtask

  task automatic t_cont;
    init();
    n_op.continue_instr = 1'b1;
    n_op.continue_gap = 1'b1;
    pulse_in();
    `CHK("continue", 1'b1, continue_o && continue_gap_o)
    n_ctl.data_valid = 1'b1;
    n_ctl.data_parity_ok = 1'b0;
    pulse_in();
    chk_diag(m(B_MDAT), 1'b1);
    `CHK("continue", 1'b0, continue_o | continue_gap_o)
    n_op.continue_instr = 1'b1;
    n_op.op_active = 1'b0;
    pulse_in();
    chk_diag(m(B_MDAT) | m(B_CONT), 1'b1);
    init();
    n_op.continue_instr = 1'b1;
    n_op.read_mem_ended = 1'b1;
    pulse_in();
    chk_diag(m(B_CONT), 1'b1);
    $display("t_cont done");
  endtask

  task automatic t_counts;
    int dif [4] = '{0, 12, 13, 13};
    for (int k = 0; k < 4; k++) begin
      init();
      n_rd.block_end = 1'b1;
      n_rd.expected_count = 12'd100;
      n_rd.actual_count = 12'd100 + 12'(dif[k]);
      n_rd.checker_connected = (k == 3);
      pulse_in();
      chk_diag(k == 1 ? m(B_BCNT) : k == 2 ? m(B_VBCT) : 15'h0000,
        k == 1 || k == 2);
      `CHK("read_end", k == 1 || k == 2, read_end_o)
    end
    $display("t_counts done");
  endtask

  task automatic t_write;
    init();
    i_op.write_op = 1'b1;
    n_op = i_op;
    n_wr.out_char_valid = 1'b1;
    n_wr.out_char = 6'h15;
    n_wr.out_parity_ok = 1'b0;
    pulse_in();
    chk_diag(m(B_OPAR), 1'b1);
    `CHK("out_char", 6'h3f, out_char_o)
    n_op.ninth_word_done = 1'b1;
    n_wr.clutch_return = 1'b0;
    pulse_in();
    chk_diag(m(B_OPAR) | m(B_CLUT), 1'b1);
    `CHK("cc", 1'b1, continue_check_o)
    n_op.group_end = 1'b1;
    pulse_in();
    `CHK("write_end", 1'b1, write_end_o)
    n_wr.sprocket_expect = 1'b1;
    pulse_in();
    repeat (6) @(posedge ref_clk_i);
    #1 chk_diag(m(B_OPAR) | m(B_CLUT) | m(B_SPRK), 1'b1);
    init();
    n_op.tenth_word = 1'b1;
    n_ctl.digit_code = 4'hf;
    pulse_in();
    for (int k = 0; k < 2; k++) begin
      n_op.group_end = 1'b1;
      pulse_in();
      `CHK("we", k == 1, write_end_o)
    end
    i_op.write_op = 1'b0;
    n_op = i_op;
    $display("t_write done");
  endtask

  task automatic t_counters;
    init();
    n_ctl.digit_code = 4'h9;
    n_ctl.mem_request = 1'b1;
    n_rd.read_sprocket = 1'b1;
    pulse_in();
    chk_diag(15'h0000, 1'b0);
    n_ctl.digit_code = 4'ha;
    n_ctl.mem_request = 1'b1;
    n_rd.read_sprocket = 1'b1;
    n_ctl.word_cnt_parity_ok = 1'b0;
    pulse_in();
    chk_diag(m(B_DCNT) | m(B_OVFL) | m(B_OSKW) | m(B_WCNT),
      1'b1);
    init();
    repeat (5) begin
      n_rd.tape_tick = 1'b1;
      pulse_in();
    end
    repeat (2) @(posedge ref_clk_i);
    #1 chk_diag(m(B_RUN), 1'b1);
    $display("t_counters done");
  endtask

  task automatic t_input;
    init();
    i_op.numeric_read_mem = 1'b1;
    n_op = i_op;
    n_rd.in_char_valid = 1'b1;
    n_rd.in_char = 5'h1a;
    n_rd.has_equivalent = 1'b0;
    pulse_in();
    chk_diag(m(B_UNTR), 1'b0);
    `CHK("in_char", PLUS_CODE, in_char_o)
    `CHK("iv", 1'b1, in_char_valid_o)
    n_rd = '{in_char_valid:1, in_parity_ok:0, has_equivalent:1,
      hash_period_gate:1, read_check_qualifier:1,
      counter_term_inverted:1, t04:1, default:'0};
    pulse_in();
    chk_diag(m(B_UNTR) | m(B_IPAR), 1'b1);
    init();
    n_rd.in_char_valid = 1'b1;
    n_rd.in_char = 5'h1a;
    n_rd.has_equivalent = 1'b0;
    n_rd.hash_period = 1'b1;
    pulse_in();
    chk_diag(m(B_UNTR), 1'b1);
    `CHK("in_char", 5'h1a, in_char_o)
    i_op.numeric_read_mem = 1'b0;
    n_op = i_op;
    init();
    n_rd.in_char_valid = 1'b1;
    n_rd.in_parity_ok = 1'b0;
    n_rd.hash_period = 1'b1;
    pulse_in();
    chk_diag(m(B_IPAR), 1'b1);
    $display("t_input done");
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    bad_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    reset_i = 1'b1;
    clk_en_i = 1'b1;
    initialise_i = 1'b0;
    instr = 7'h00;
    sel = 4'h0;
    i_op = '{op_active:1, default:'0};
    i_ctl = '{word_cnt_parity_ok:1, addr_parity_ok:1, data_parity_ok:1,
      default:'0};
    i_wr = '{clutch_return:1, out_parity_ok:1, default:'0};
    i_rd = '{in_parity_ok:1, has_equivalent:1, default:'0};
    op_i = i_op;
    ctl_i = i_ctl;
    wr_i = i_wr;
    rd_i = i_rd;
    n_op = i_op;
    n_ctl = i_ctl;
    n_wr = i_wr;
    n_rd = i_rd;
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_select();
    t_cont();
    t_counts();
    t_write();
    t_counters();
    t_input();
    tally_and_finish();
  end
endmodule
